// [hw/bpc_pkg.sv]
// Contract
// - Any inbox write forces pending bit 15 high
// - Inbox read returns old flag, then clears
// - Outbox written by bitstream side, bit15 forced
// - Media read of outbox returns, clears flag
// - Control bits 3,4 drive signal pins directly
// - Host snoop aliases never touch pending flags
// - Program counter resets to zero, software loadable
// - Exception pc holds faulting instruction address
// - Halt/reset powers up zero (code reads 0x0006: halt, ack set); zero write halts+resets
// - Bit 0 low holds processor in reset
// - Bit 1 halt/go: zero runs, one halts
// - Bit 2 acknowledges halt after pipeline drains
// - Halt copies pc to exception pc, nullifies
// - Halt waits for stalls; may never acknowledge
// - Cause bits 0-7 flag latest exception kind
// - Odd halfword load/store, break raise exceptions
// - Bad opcode, out-of-memory fetch raise exceptions
// - Bitstream error branches to 0x00c0, keeps running
// - Odd write-buffer address raises exception
// - Fifo empty bit0 resets one; full at 16
// - Fifo control bit2 holds fifo pointers reset
package bpc_pkg;
	// Register selects on the common bus; the two snoop selects alias the inbox and outbox
	localparam logic [3:0] BPC_SEL_INBOX = 4'h0;
	localparam logic [3:0] BPC_SEL_OUTBOX = 4'h1;
	localparam logic [3:0] BPC_SEL_INBOX_SNOOP = 4'h2;
	localparam logic [3:0] BPC_SEL_OUTBOX_SNOOP = 4'h3;
	localparam logic [3:0] BPC_SEL_PC = 4'h4;
	localparam logic [3:0] BPC_SEL_EPC = 4'h5;
	localparam logic [3:0] BPC_SEL_HALT_RESET = 4'h6;
	localparam logic [3:0] BPC_SEL_CAUSE = 4'h7;
	localparam logic [3:0] BPC_SEL_FIFO_CS = 4'h8;
	localparam logic [3:0] BPC_SEL_AVALID = 4'h9;
	// Field positions
	localparam int BPC_PEND_BIT = 15;
	localparam int BPC_HR_RUN = 0;
	localparam int BPC_HR_HALT = 1;
	localparam int BPC_HR_ACK = 2;
	localparam int BPC_FIFO_EMPTY = 0;
	localparam int BPC_FIFO_FULL = 1;
	localparam int BPC_FIFO_RST = 2;
	localparam int BPC_FIFO_MSIG = 3;
	localparam int BPC_FIFO_BSIG = 4;
	localparam int BPC_CAUSE_ADEL = 0;
	localparam int BPC_CAUSE_ADES = 1;
	localparam int BPC_CAUSE_BREAK = 2;
	localparam int BPC_CAUSE_WATCH = 3;
	localparam int BPC_CAUSE_RSVD = 4;
	localparam int BPC_CAUSE_IADDR = 5;
	localparam int BPC_CAUSE_BSERR = 6;
	localparam int BPC_CAUSE_WBADDR = 7;
	// Reset values and bitstream error vector
	localparam logic [15:0] BPC_MBOX_RST = 16'h0000;
	localparam logic [15:0] BPC_PC_RST = 16'h0000;
	localparam logic [15:0] BPC_AVALID_RST = 16'h0000;
	localparam logic [1:0] BPC_SIG_RST = 2'h0;
	localparam logic [15:0] BPC_ERR_VECTOR = 16'h00c0;
	// Fifo depth
	localparam int BPC_FIFO_DEPTH = 16;
	localparam logic [4:0] BPC_FIFO_FULL_CNT = 5'h10;
	// Requesters on the common bus
	typedef enum logic [1:0] {
		BPC_SRC_MEDIA,
		BPC_SRC_BITSTREAM,
		BPC_SRC_HOST
	} bpc_src_t;
	// Halt sequencer states
	typedef enum logic [1:0] {
		BPC_ST_HALTED,
		BPC_ST_RUN,
		BPC_ST_DRAIN
	} bpc_state_t;
endpackage : bpc_pkg

// [hw/bpc_mailbox.sv]
module bpc_mailbox
	import bpc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Access strobes
	input wire logic i_wr,
	input wire logic i_rd_clear,
	input wire logic [14:0] i_wdata,
	// Contents
	output logic [15:0] o_value
);
	logic [14:0] message_reg;
	logic pending_reg;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			message_reg <= BPC_MBOX_RST[14:0];
		end else if (i_wr) begin
			message_reg <= i_wdata;
		end
	end

	// A write in the same cycle as a clearing read wins
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			pending_reg <= BPC_MBOX_RST[BPC_PEND_BIT];
		end else if (i_wr) begin
			pending_reg <= 1'b1;
		end else if (i_rd_clear) begin
			pending_reg <= 1'b0;
		end
	end

	assign o_value = {pending_reg, message_reg};
endmodule : bpc_mailbox

// [hw/bpc_ctrl_regs.sv]
module bpc_ctrl_regs
	import bpc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Common register bus
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [3:0] i_reg_sel,
	input wire bpc_src_t i_reg_src,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	// Processor core status
	input wire logic [15:0] i_core_pc,
	input wire logic i_core_busy,
	input wire logic i_exc_adel,
	input wire logic i_exc_ades,
	input wire logic i_exc_break,
	input wire logic i_exc_rsvd,
	input wire logic i_exc_iaddr,
	input wire logic i_exc_bserr,
	input wire logic i_exc_wbaddr,
	input wire logic [15:0] i_exc_pc,
	// Input fifo occupancy
	input wire logic [4:0] i_fifo_count,
	// Processor control
	output logic o_core_reset_b,
	output logic o_core_run,
	output logic o_core_nullify,
	output logic o_pc_load,
	output logic [15:0] o_pc_value,
	output logic o_fifo_ptr_reset,
	output logic [5:0] o_avalid_ptr,
	// Chip signal pins
	output logic o_media_side_signal_bit,
	output logic o_bitstream_side_signal_bit
);
	bpc_state_t state_reg;
	logic [15:0] pc_reg;
	logic pc_load_reg;
	logic [15:0] epc_reg;
	logic [7:0] cause_reg;
	logic run_enable_reg;
	logic fifo_rst_reg;
	logic [1:0] sig_reg;
	logic [15:0] avalid_reg;
	logic [15:0] inbox_value;
	logic [15:0] outbox_value;
	logic inbox_wr;
	logic outbox_wr;
	logic inbox_rd_clear;
	logic outbox_rd_clear;
	logic hr_wr;
	logic halt_req;
	logic go_req;
	logic [7:0] exc_vec;
	logic fifo_empty;
	logic fifo_full;

	function automatic logic sel_hit(input logic [3:0] sel, input logic [3:0] reg_id);
		sel_hit = (sel == reg_id);
	endfunction : sel_hit

	// Mailbox strobes; media side only reads the outbox, its writes drop
	assign inbox_wr = i_reg_wr && sel_hit(i_reg_sel, BPC_SEL_INBOX);
	assign outbox_wr = i_reg_wr && sel_hit(i_reg_sel, BPC_SEL_OUTBOX)
		&& (i_reg_src != BPC_SRC_MEDIA);
	// Snoop selects never raise a clear strobe
	assign inbox_rd_clear = i_reg_rd && sel_hit(i_reg_sel, BPC_SEL_INBOX);
	// Media and host reads consume outbox mail; bitstream reads just peek
	assign outbox_rd_clear = i_reg_rd && sel_hit(i_reg_sel, BPC_SEL_OUTBOX)
		&& (i_reg_src != BPC_SRC_BITSTREAM);

	bpc_mailbox u_inbox (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_wr(inbox_wr),
		.i_rd_clear(inbox_rd_clear),
		.i_wdata(i_reg_wdata[14:0]),
		.o_value(inbox_value)
	);

	bpc_mailbox u_outbox (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_wr(outbox_wr),
		.i_rd_clear(outbox_rd_clear),
		.i_wdata(i_reg_wdata[14:0]),
		.o_value(outbox_value)
	);

	// Halt/reset register writes
	assign hr_wr = i_reg_wr && sel_hit(i_reg_sel, BPC_SEL_HALT_RESET);
	assign halt_req = hr_wr && i_reg_wdata[BPC_HR_HALT];
	assign go_req = hr_wr && !i_reg_wdata[BPC_HR_HALT];

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			run_enable_reg <= 1'b0;
		end else if (hr_wr) begin
			run_enable_reg <= i_reg_wdata[BPC_HR_RUN];
		end
	end

	// Halt sequencer: halting drains in-flight work before acknowledge
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			state_reg <= BPC_ST_HALTED;
		end else begin
			case (state_reg)
				BPC_ST_HALTED: begin
					if (go_req && i_reg_wdata[BPC_HR_RUN]) begin
						state_reg <= BPC_ST_RUN;
					end
				end
				BPC_ST_RUN: begin
					if (hr_wr && !i_reg_wdata[BPC_HR_RUN]) begin
						state_reg <= BPC_ST_HALTED;
					end else if (halt_req) begin
						state_reg <= BPC_ST_DRAIN;
					end
				end
				BPC_ST_DRAIN: begin
					// Stalls keep busy high, so this may wait forever
					if (hr_wr && !i_reg_wdata[BPC_HR_RUN]) begin
						state_reg <= BPC_ST_HALTED;
					end else if (!i_core_busy) begin
						state_reg <= BPC_ST_HALTED;
					end
				end
				default: begin
					state_reg <= BPC_ST_HALTED;
				end
			endcase
		end
	end

	// Program counter; load request pulses to the core
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			pc_reg <= BPC_PC_RST;
			pc_load_reg <= 1'b0;
		end else if (i_reg_wr && sel_hit(i_reg_sel, BPC_SEL_PC)) begin
			pc_reg <= i_reg_wdata;
			pc_load_reg <= 1'b1;
		end else if (i_exc_bserr) begin
			pc_reg <= BPC_ERR_VECTOR;
			pc_load_reg <= 1'b1;
		end else begin
			pc_reg <= i_core_pc;
			pc_load_reg <= 1'b0;
		end
	end

	assign exc_vec = {i_exc_wbaddr, i_exc_bserr, i_exc_iaddr, i_exc_rsvd,
		1'b0, i_exc_break, i_exc_ades, i_exc_adel};

	// Exception pc; left unreset on purpose, value undefined at power up
	always_ff @(posedge i_clk_sys) begin
		if (state_reg == BPC_ST_RUN && halt_req) begin
			epc_reg <= i_core_pc;
		end else if (|exc_vec) begin
			epc_reg <= i_exc_pc;
		end
	end

	// Latest exception only; watchpoint bit stays zero
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			cause_reg <= 8'h00;
		end else if (|exc_vec) begin
			cause_reg <= exc_vec;
		end
	end

	// Fifo control and signal pins
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			fifo_rst_reg <= 1'b0;
			sig_reg <= BPC_SIG_RST;
		end else if (i_reg_wr && sel_hit(i_reg_sel, BPC_SEL_FIFO_CS)) begin
			fifo_rst_reg <= i_reg_wdata[BPC_FIFO_RST];
			sig_reg <= {i_reg_wdata[BPC_FIFO_BSIG], i_reg_wdata[BPC_FIFO_MSIG]};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			avalid_reg <= BPC_AVALID_RST;
		end else if (i_reg_wr && sel_hit(i_reg_sel, BPC_SEL_AVALID)) begin
			avalid_reg <= i_reg_wdata;
		end
	end

	// Flags forced while held in reset, so empty reads one from reset
	assign fifo_empty = fifo_rst_reg || !i_rst_b || (i_fifo_count == 5'h00);
	assign fifo_full = !fifo_rst_reg && i_rst_b && (i_fifo_count == BPC_FIFO_FULL_CNT);

	// Read mux; unmapped selects read zero
	always_comb begin
		o_reg_rdata = 16'h0000;
		if (sel_hit(i_reg_sel, BPC_SEL_INBOX)) begin
			o_reg_rdata = inbox_value;
		end else if (sel_hit(i_reg_sel, BPC_SEL_OUTBOX)) begin
			o_reg_rdata = outbox_value;
		end else if (sel_hit(i_reg_sel, BPC_SEL_INBOX_SNOOP)) begin
			if (i_reg_src != BPC_SRC_MEDIA) begin
				o_reg_rdata = inbox_value;
			end
		end else if (sel_hit(i_reg_sel, BPC_SEL_OUTBOX_SNOOP)) begin
			if (i_reg_src != BPC_SRC_MEDIA) begin
				o_reg_rdata = outbox_value;
			end
		end else if (sel_hit(i_reg_sel, BPC_SEL_PC)) begin
			o_reg_rdata = pc_reg;
		end else if (sel_hit(i_reg_sel, BPC_SEL_EPC)) begin
			o_reg_rdata = epc_reg;
		end else if (sel_hit(i_reg_sel, BPC_SEL_HALT_RESET)) begin
			o_reg_rdata[BPC_HR_RUN] = run_enable_reg;
			o_reg_rdata[BPC_HR_HALT] = (state_reg != BPC_ST_RUN);
			o_reg_rdata[BPC_HR_ACK] = (state_reg == BPC_ST_HALTED);
		end else if (sel_hit(i_reg_sel, BPC_SEL_CAUSE)) begin
			o_reg_rdata[7:0] = cause_reg;
		end else if (sel_hit(i_reg_sel, BPC_SEL_FIFO_CS)) begin
			o_reg_rdata[BPC_FIFO_EMPTY] = fifo_empty;
			o_reg_rdata[BPC_FIFO_FULL] = fifo_full;
			o_reg_rdata[BPC_FIFO_RST] = fifo_rst_reg;
			o_reg_rdata[BPC_FIFO_MSIG] = sig_reg[0];
			o_reg_rdata[BPC_FIFO_BSIG] = sig_reg[1];
		end else if (sel_hit(i_reg_sel, BPC_SEL_AVALID)) begin
			o_reg_rdata = avalid_reg;
		end
	end

	assign o_core_reset_b = run_enable_reg;
	assign o_core_run = (state_reg == BPC_ST_RUN) && run_enable_reg;
	assign o_core_nullify = (state_reg == BPC_ST_DRAIN);
	assign o_pc_load = pc_load_reg;
	assign o_pc_value = pc_reg;
	assign o_fifo_ptr_reset = fifo_rst_reg;
	assign o_avalid_ptr = avalid_reg[5:0];
	assign o_media_side_signal_bit = sig_reg[0];
	assign o_bitstream_side_signal_bit = sig_reg[1];
endmodule : bpc_ctrl_regs

// [verification/bpc_ctrl_regs_properties.sv]
module bpc_ctrl_regs_properties
	import bpc_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Register bus
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [3:0] i_reg_sel,
	input wire bpc_src_t i_reg_src,
	input wire logic [15:0] i_reg_wdata,
	input wire logic [15:0] o_reg_rdata,
	// Core and fifo
	input wire logic i_core_busy,
	input wire logic i_exc_bserr,
	input wire logic [4:0] i_fifo_count,
	input wire logic o_core_reset_b,
	input wire logic o_core_run,
	input wire logic o_core_nullify,
	input wire logic o_pc_load,
	input wire logic [15:0] o_pc_value,
	input wire logic o_fifo_ptr_reset,
	input wire logic o_media_side_signal_bit,
	input wire logic o_bitstream_side_signal_bit
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	inbox_set_a: assert property (
		(i_reg_wr && i_reg_sel == BPC_SEL_INBOX) ##1
		(i_reg_sel == BPC_SEL_INBOX_SNOOP && i_reg_src == BPC_SRC_HOST) |-> o_reg_rdata[15])
		else $error("inbox flag not set by write");
	inbox_clear_a: assert property (
		(i_reg_rd && !i_reg_wr && i_reg_sel == BPC_SEL_INBOX) ##1
		(i_reg_sel == BPC_SEL_INBOX) |-> !o_reg_rdata[15])
		else $error("inbox flag not cleared by read");
	outbox_clear_a: assert property (
		(i_reg_rd && !i_reg_wr && i_reg_sel == BPC_SEL_OUTBOX && i_reg_src == BPC_SRC_MEDIA)
		##1 (i_reg_sel == BPC_SEL_OUTBOX) |-> !o_reg_rdata[15])
		else $error("outbox flag not cleared by media read");
	snoop_refuse_a: assert property (
		(i_reg_sel == BPC_SEL_INBOX_SNOOP && i_reg_src == BPC_SRC_MEDIA) |-> o_reg_rdata == 16'h0000)
		else $error("media reached a snoop alias");
	pin_drive_a: assert property (
		(i_reg_wr && i_reg_sel == BPC_SEL_FIFO_CS) |=> o_media_side_signal_bit == $past(i_reg_wdata[3])
		&& o_bitstream_side_signal_bit == $past(i_reg_wdata[4]))
		else $error("signal pins differ from written bits");
	fifo_reset_a: assert property (
		(i_reg_wr && i_reg_sel == BPC_SEL_FIFO_CS) |=> o_fifo_ptr_reset == $past(i_reg_wdata[2]))
		else $error("fifo pointer reset differs from written bit");
	// Stable count lets a registered flag path pass too
	fifo_flags_a: assert property (
		(i_reg_sel == BPC_SEL_FIFO_CS && $stable(i_fifo_count)) |->
		o_reg_rdata[1:0] == {i_fifo_count == 5'h10, i_fifo_count == 5'h00})
		else $error("fifo flags wrong");
	halt_reset_a: assert property (
		(i_reg_wr && i_reg_sel == BPC_SEL_HALT_RESET && !i_reg_wdata[0]) |=> !o_core_reset_b && !o_core_run)
		else $error("zero write did not halt and reset");
	drain_hold_a: assert property (
		(o_core_nullify && i_core_busy && !(i_reg_wr && i_reg_sel == BPC_SEL_HALT_RESET)) |=> o_core_nullify)
		else $error("drain ended while core busy");
	error_branch_a: assert property (
		i_exc_bserr |=> o_pc_load && o_pc_value == 16'h00c0)
		else $error("bitstream error did not branch");
endmodule : bpc_ctrl_regs_properties

bind bpc_ctrl_regs bpc_ctrl_regs_properties i_bpc_ctrl_regs_properties (.i_clk_sys, .i_rst_b,
	.i_reg_wr, .i_reg_rd, .i_reg_sel, .i_reg_src, .i_reg_wdata, .o_reg_rdata, .i_core_busy,
	.i_exc_bserr, .i_fifo_count, .o_core_reset_b, .o_core_run, .o_core_nullify, .o_pc_load,
	.o_pc_value, .o_fifo_ptr_reset, .o_media_side_signal_bit, .o_bitstream_side_signal_bit);

// [verification/bpc_core_model.sv]
module bpc_core_model #(
	parameter int DRAIN_CYCLES = 4
) (
	// Clock and control
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_core_reset_b,
	input wire logic i_core_run,
	input wire logic i_core_nullify,
	input wire logic i_pc_load,
	input wire logic [15:0] i_pc_value,
	// Status
	output logic [15:0] o_core_pc,
	output logic o_core_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	int drain_cnt;
	// Loaded pc survives core reset, so a preset start address sticks
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			o_core_pc <= 16'h0000;
		end else if (i_pc_load) begin
			o_core_pc <= i_pc_value;
		end else if (i_core_reset_b && i_core_run && !i_core_nullify) begin
			o_core_pc <= o_core_pc + 16'h0002;
		end
	end
	// Work in flight keeps busy up so halt must really wait
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b || !i_core_reset_b) begin
			drain_cnt <= 0;
		end else if (i_core_run && !i_core_nullify) begin
			drain_cnt <= DRAIN_CYCLES;
		end else if (drain_cnt > 0) begin
			drain_cnt <= drain_cnt - 1;
		end
	end
	assign o_core_busy = (drain_cnt != 0);
endmodule : bpc_core_model

// [verification/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bpc_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	logic rw = 1'b0;
	logic rr = 1'b0;
	logic [3:0] sel = 4'h0;
	bpc_src_t src = BPC_SRC_HOST;
	logic [15:0] wd = 16'h0000, exc_pc = 16'h0000, rdata, core_pc, pcv, seen, pc_at;
	logic [7:0] exc = 8'h00;
	logic [4:0] fcnt = 5'h00;
	logic core_rst_b, run, nul, busy, pcl, fpr, msig, bsig;
	logic [5:0] avp;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	int cnt_tab[4] = '{0, 1, 15, 16};
	always #2.5 i_clk_sys = ~i_clk_sys;
	bpc_ctrl_regs i_bpc_ctrl_regs (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg_wr(rw),
		.i_reg_rd(rr), .i_reg_sel(sel), .i_reg_src(src), .i_reg_wdata(wd), .o_reg_rdata(rdata),
		.i_core_pc(core_pc), .i_core_busy(busy), .i_exc_adel(exc[0]), .i_exc_ades(exc[1]),
		.i_exc_break(exc[2]), .i_exc_rsvd(exc[4]), .i_exc_iaddr(exc[5]), .i_exc_bserr(exc[6]),
		.i_exc_wbaddr(exc[7]), .i_exc_pc(exc_pc), .i_fifo_count(fcnt), .o_core_reset_b(core_rst_b),
		.o_core_run(run), .o_core_nullify(nul), .o_pc_load(pcl), .o_pc_value(pcv),
		.o_fifo_ptr_reset(fpr), .o_avalid_ptr(avp), .o_media_side_signal_bit(msig),
		.o_bitstream_side_signal_bit(bsig));
	bpc_core_model i_bpc_core_model (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_core_reset_b(core_rst_b), .i_core_run(run), .i_core_nullify(nul), .i_pc_load(pcl),
		.i_pc_value(pcv), .o_core_pc(core_pc), .o_core_busy(busy));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// One bus cycle, entered just after an edge; read data taken at the edge
	task automatic acc(input logic w, input logic r, input logic [3:0] a, input bpc_src_t s,
		input logic [15:0] d);
		rw = w;
		rr = r;
		sel = a;
		src = s;
		wd = d;
		@(posedge i_clk_sys);
		seen = rdata;
		if (w) pc_at = core_pc;
		#1;
	endtask : acc
	task automatic wr(input logic [3:0] a, input bpc_src_t s, input logic [15:0] d);
		acc(1'b1, 1'b0, a, s, d);
	endtask : wr
	task automatic rd(input logic [3:0] a, input bpc_src_t s, input logic [15:0] e);
		acc(1'b0, 1'b1, a, s, 16'h0000);
		chk(seen, e);
	endtask : rd
	task automatic idle();
		acc(1'b0, 1'b0, sel, src, 16'h0000);
	endtask : idle
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : stop_test
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		repeat (12) @(posedge i_clk_sys);
		#1;
		i_rst_b = 1'b1;
		rd(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0006);
		rd(BPC_SEL_PC, BPC_SRC_HOST, 16'h0000);
		rd(BPC_SEL_FIFO_CS, BPC_SRC_HOST, 16'h0001);
		rd(BPC_SEL_OUTBOX, BPC_SRC_HOST, 16'h0000);
		chk({15'h0, core_rst_b}, 16'h0000);
		$display("Test reset done");
		for (int i = 0; i < 3; i++) begin
			wr(BPC_SEL_INBOX, bpc_src_t'(i), 16'h0005 + 16'(i));
			rd(BPC_SEL_INBOX_SNOOP, BPC_SRC_HOST, 16'h8005 + 16'(i));
			rd(BPC_SEL_INBOX_SNOOP, BPC_SRC_MEDIA, 16'h0000);
			rd(BPC_SEL_INBOX, BPC_SRC_BITSTREAM, 16'h8005 + 16'(i));
			rd(BPC_SEL_INBOX, BPC_SRC_MEDIA, 16'h0005 + 16'(i));
		end
		acc(1'b1, 1'b1, BPC_SEL_INBOX, BPC_SRC_MEDIA, 16'h0011);
		rd(BPC_SEL_INBOX_SNOOP, BPC_SRC_HOST, 16'h8011);
		wr(BPC_SEL_OUTBOX, BPC_SRC_BITSTREAM, 16'h7fff);
		rd(BPC_SEL_OUTBOX_SNOOP, BPC_SRC_HOST, 16'hffff);
		rd(BPC_SEL_OUTBOX_SNOOP, BPC_SRC_MEDIA, 16'h0000);
		rd(BPC_SEL_OUTBOX, BPC_SRC_BITSTREAM, 16'hffff);
		rd(BPC_SEL_OUTBOX, BPC_SRC_MEDIA, 16'hffff);
		rd(BPC_SEL_OUTBOX, BPC_SRC_MEDIA, 16'h7fff);
		rd(BPC_SEL_OUTBOX_SNOOP, BPC_SRC_HOST, 16'h7fff);
		wr(BPC_SEL_OUTBOX, BPC_SRC_MEDIA, 16'h1234);
		rd(BPC_SEL_OUTBOX_SNOOP, BPC_SRC_HOST, 16'h7fff);
		$display("Test mailbox done");
		wr(BPC_SEL_FIFO_CS, BPC_SRC_HOST, 16'h001c);
		rd(BPC_SEL_FIFO_CS, BPC_SRC_HOST, 16'h001d);
		chk({13'h0, msig, bsig, fpr}, 16'h0007);
		wr(BPC_SEL_FIFO_CS, BPC_SRC_HOST, 16'h0000);
		chk({13'h0, msig, bsig, fpr}, 16'h0000);
		foreach (cnt_tab[i]) begin
			fcnt = 5'(cnt_tab[i]);
			idle();
			rd(BPC_SEL_FIFO_CS, BPC_SRC_HOST, {14'h0, cnt_tab[i] == 16, cnt_tab[i] == 0});
		end
		wr(BPC_SEL_AVALID, BPC_SRC_HOST, 16'h002a);
		chk({10'h0, avp}, 16'h002a);
		rd(BPC_SEL_AVALID, BPC_SRC_HOST, 16'h002a);
		$display("Test fifo done");
		wr(BPC_SEL_PC, BPC_SRC_HOST, 16'h0100);
		chk(pcv, 16'h0100);
		wr(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0001);
		repeat (8) idle();
		rd(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0001);
		chk({14'h0, core_rst_b, run}, 16'h0003);
		wr(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0003);
		acc(1'b0, 1'b1, BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0000);
		chk(seen & 16'h0004, 16'h0000);
		for (int n = 0; n < 20 && seen[2] !== 1'b1; n++) acc(1'b0, 1'b1, sel, src, 16'h0000);
		chk(seen, 16'h0007);
		rd(BPC_SEL_EPC, BPC_SRC_HOST, pc_at);
		wr(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0001);
		idle();
		wr(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0000);
		chk({14'h0, core_rst_b, run}, 16'h0000);
		wr(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0002);
		rd(BPC_SEL_HALT_RESET, BPC_SRC_HOST, 16'h0006);
		$display("Test halt done");
		for (int i = 0; i < 8; i++) begin
			if (i == 3) continue;
			exc = 8'h01 << i;
			exc_pc = 16'h0040 + 16'(i);
			idle();
			exc = 8'h00;
			if (i == 6) chk({pcl, pcv[14:0]}, 16'h80c0);
			rd(BPC_SEL_CAUSE, BPC_SRC_HOST, 16'h0001 << i);
			rd(BPC_SEL_EPC, BPC_SRC_HOST, 16'h0040 + 16'(i));
		end
		$display("Test exception done");
		stop_test();
	end
endmodule : tb
